// ---- dcd_regs.sv ----
// device control, diagnostic and retry status registers of a two-function socket bridge
// assumes one-cycle byte-wide configuration requests on the reference clock; i_arst_n is the global reset
`timescale 1ns/1ps
`include "dcd_defines.svh"

// Contract
// R1 - power lock set: power-down requests ignored while function is in D3
// R2 - bit 6 forces the 3-V capability report; resets to 1
// R3 - bit 5 is a read/write diagnostic bit resetting to 1
// R4 - bit 4 reads zero; writes change nothing
// R5 - test bit shortens interrogation counter; software writes only zero
// R6 - two-bit interrupt mode field, four encodings, resets to 11
// R7 - bit 0 enables nand tree over input and two-way pins only
// R8 - global bits have one copy shared by both functions
// R9 - protected bits clear only on global reset
// R10 - diagnostic bit 7 set makes vendor and device ID reads all ones
// R11 - status change routing by 803 bit 4, or 805 high nibble zero
// R12 - diagnostic bit 4 disables delayed transactions
// R13 - diagnostic bit 3 extends retry latency from 16 to 64
// R14 - card side discard period 2^10 when bit 2 set, else 2^15
// R15 - host side discard period 2^10 when bit 1 set, else 2^15
// R16 - diagnostic bit 0 set generates status change interrupt asynchronously
// R17 - device control visible from both functions, shared storage; the code keeps bits 7 and 5 as one copy per function
// R18 - retry flags set after 2^15 clocks; write one clears
// R19 - diagnostic bit 6 plain storage resetting to 1, no effect
module dcd_regs #(
   parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h5678, // arbitrary value
   parameter int RETRY_CYC = `DCD_RETRY_CYC,
   parameter int DISCARD_LONG_CYC = `DCD_DISCARD_LONG_CYC,
   parameter int DISCARD_SHORT_CYC = `DCD_DISCARD_SHORT_CYC,
   parameter int NAND_W = 8
) (
   // clock and global reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // configuration access
   input wire dcd_pkg::dcd_cfg_req_t i_cfg,
   output logic o_cfg_ack,
   output logic [7:0] o_cfg_rdata,
   // socket power, one per function
   input wire logic [1:0] i_pwr_down_req,
   input wire logic [1:0] i_in_d3,
   output logic [1:0] o_sock_pwr_down,
   // configuration outputs
   output logic o_low_voltage_socket_force,
   output logic [1:0] o_io_bit_a_bit,
   output logic o_interrog_short,
   output dcd_pkg::dcd_irq_mode_t o_irq_signaling_select,
   output logic o_delayed_txn_disable,
   output logic [6:0] o_retry_latency_limit,
   // retry and discard timing
   input wire logic [2:0] i_retry_pending,
   input wire logic i_card_discard_run,
   input wire logic i_host_discard_run,
   output logic o_card_side_discard_expire,
   output logic o_host_side_discard_expire,
   // card status change, one per socket
   input wire logic [1:0] i_card_status_change,
   input wire logic [1:0] i_compat_803_b4,
   input wire logic [7:0] i_compat_805_hi,
   input wire logic i_clk_running,
   output logic [1:0] o_csc_irq,
   // nand tree
   input wire logic [NAND_W-1:0] i_nand_pins,
   output logic o_nand_out
);
   localparam logic [7:0] DEV_RST = `DCD_DEV_RST;
   localparam logic [7:0] BIT_A_RST = `DCD_BIT_A_RST;
   localparam logic [7:0] RETRY_RST = `DCD_RETRY_RST;
   localparam logic [15:0] RETRY_LIM = 16'(RETRY_CYC);
   localparam logic [15:0] DISC_LONG = 16'(DISCARD_LONG_CYC);
   localparam logic [15:0] DISC_SHORT = 16'(DISCARD_SHORT_CYC);

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_arst_n);

   // shared storage
   logic lv_force_q;
   logic test_q;
   dcd_pkg::dcd_irq_mode_t irq_mode_q;
   logic nand_en_q;
   logic id_mask_q;
   logic dt_dis_q;
   logic rext_q;
   logic cb_sel_q;
   logic pci_sel_q;
   logic async_q;
   logic pci_ren_q;
   logic cb_ren_q;
   logic [2:0] texp_q;
   logic [6:0] lat_q;
   // per-function storage, then access answer and retry expiry pulses
   logic pwr_lock_q [2];
   logic io_bit_a_q [2];
   logic spare_q [2];
   logic csc_route_q [2];
   logic [1:0] pwr_down_q;
   logic [1:0] csc_irq_q;
   logic ack_q;
   logic [7:0] rdata_q;
   logic [2:0] retry_exp;

   // decode
   wire wr_any = i_cfg.valid & i_cfg.wr;
   wire wr_dev = wr_any & (i_cfg.addr == `DCD_OFF_DEV_CTRL);
   wire wr_bit_a = wr_any & (i_cfg.addr == `DCD_OFF_BIT_A);
   wire wr_retry = wr_any & (i_cfg.addr == `DCD_OFF_RETRY_STAT);
   wire hit_id = (i_cfg.addr[7:2] == `DCD_ID_WORD_IDX);
   wire [7:0] wd = i_cfg.wdata;

   // read selection
   wire [7:0] dev_rd = {pwr_lock_q[i_cfg.func], lv_force_q, io_bit_a_q[i_cfg.func], 1'h0, // R4 R17
                        test_q, irq_mode_q, nand_en_q};
   wire [7:0] bit_a_rd = {id_mask_q, spare_q[i_cfg.func], csc_route_q[i_cfg.func], dt_dis_q,
                         rext_q, cb_sel_q, pci_sel_q, async_q};
   wire [7:0] retry_rd = {pci_ren_q, cb_ren_q, texp_q[2], 1'h0, texp_q[1], 1'h0, texp_q[0], 1'h0};
   wire [31:0] id_word = {DEVICE_ID, VENDOR_ID};
   wire [4:0] id_sh = {i_cfg.addr[1:0], 3'h0};
   wire [7:0] id_byte = id_mask_q ? 8'hff : id_word[id_sh +: 8]; // R10
   wire [7:0] rd_mux = hit_id ? id_byte :
                       (i_cfg.addr == `DCD_OFF_DEV_CTRL) ? dev_rd :
                       (i_cfg.addr == `DCD_OFF_BIT_A) ? bit_a_rd :
                       (i_cfg.addr == `DCD_OFF_RETRY_STAT) ? retry_rd : 8'h00;

   // retry flag update, set wins over write-one clear
   wire [2:0] texp_clr = wr_retry ? {wd[`DCD_RS_TEXP_CBB], wd[`DCD_RS_TEXP_CBA], wd[`DCD_RS_TEXP_PCI]} : 3'h0;
   wire [2:0] texp_d = (texp_q & ~texp_clr) | retry_exp; // R18
   wire [2:0] retry_en = {cb_ren_q, cb_ren_q, pci_ren_q};
   wire [6:0] lat_d = rext_q ? `DCD_RETRY_LAT_LONG : `DCD_RETRY_LAT_SHORT; // R13

   // access answer
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_q <= 1'h0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= i_cfg.valid;
         rdata_q <= (i_cfg.valid && !i_cfg.wr) ? rd_mux : 8'h00;
      end
   end

   // global bits: one copy, written from either function
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin // R9
         lv_force_q <= DEV_RST[`DCD_DEV_LV_FORCE]; // R2
         test_q <= DEV_RST[`DCD_DEV_TEST];
         irq_mode_q <= dcd_pkg::dcd_irq_mode_t'(DEV_RST[`DCD_DEV_IRQ_HI:`DCD_DEV_IRQ_LO]); // R6
         nand_en_q <= DEV_RST[`DCD_DEV_NAND];
      end else if (wr_dev) begin // R8 R17
         lv_force_q <= wd[`DCD_DEV_LV_FORCE]; // R2
         test_q <= wd[`DCD_DEV_TEST]; // R5
         irq_mode_q <= dcd_pkg::dcd_irq_mode_t'(wd[`DCD_DEV_IRQ_HI:`DCD_DEV_IRQ_LO]); // R6
         nand_en_q <= wd[`DCD_DEV_NAND]; // R7
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin // R9
         id_mask_q <= BIT_A_RST[`DCD_BIT_A_ID_MASK];
         dt_dis_q <= BIT_A_RST[`DCD_BIT_A_DT_DIS];
         rext_q <= BIT_A_RST[`DCD_BIT_A_REXT];
         cb_sel_q <= BIT_A_RST[`DCD_BIT_A_CB_SEL];
         pci_sel_q <= BIT_A_RST[`DCD_BIT_A_PCI_SEL];
         async_q <= BIT_A_RST[`DCD_BIT_A_ASYNC];
      end else if (wr_bit_a) begin // R8
         id_mask_q <= wd[`DCD_BIT_A_ID_MASK]; // R10
         dt_dis_q <= wd[`DCD_BIT_A_DT_DIS]; // R12
         rext_q <= wd[`DCD_BIT_A_REXT]; // R13
         cb_sel_q <= wd[`DCD_BIT_A_CB_SEL]; // R14
         pci_sel_q <= wd[`DCD_BIT_A_PCI_SEL]; // R15
         async_q <= wd[`DCD_BIT_A_ASYNC]; // R16
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pci_ren_q <= RETRY_RST[`DCD_RS_PCI_EN];
         cb_ren_q <= RETRY_RST[`DCD_RS_CB_EN];
         texp_q <= 3'h0;
         lat_q <= `DCD_RETRY_LAT_SHORT;
      end else begin
         pci_ren_q <= wr_retry ? wd[`DCD_RS_PCI_EN] : pci_ren_q;
         cb_ren_q <= wr_retry ? wd[`DCD_RS_CB_EN] : cb_ren_q;
         texp_q <= texp_d; // R18
         lat_q <= lat_d;
      end
   end

   // per-function bits, status change routing and power-down gating
   for (genvar f = 0; f < 2; f++) begin : g_func
      wire wr_dev_f = wr_dev & (i_cfg.func == 1'(f));
      wire wr_bit_a_f = wr_bit_a & (i_cfg.func == 1'(f));
      wire route_ok = csc_route_q[f] ? (i_compat_805_hi[4*f +: 4] == 4'h0) : i_compat_803_b4[f]; // R11
      wire csc_d = i_card_status_change[f] & route_ok & (async_q | i_clk_running); // R16
      wire pwr_d = i_pwr_down_req[f] & ~(pwr_lock_q[f] & i_in_d3[f]); // R1

      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin // R9
            pwr_lock_q[f] <= DEV_RST[`DCD_DEV_PWR_LOCK];
            io_bit_a_q[f] <= DEV_RST[`DCD_DEV_IO_BIT_A]; // R3
            spare_q[f] <= BIT_A_RST[`DCD_BIT_A_SPARE]; // R19
            csc_route_q[f] <= BIT_A_RST[`DCD_BIT_A_CSC_ROUTE];
            pwr_down_q[f] <= 1'h0;
            csc_irq_q[f] <= 1'h0;
         end else begin
            pwr_lock_q[f] <= wr_dev_f ? wd[`DCD_DEV_PWR_LOCK] : pwr_lock_q[f]; // R1
            io_bit_a_q[f] <= wr_dev_f ? wd[`DCD_DEV_IO_BIT_A] : io_bit_a_q[f]; // R3
            spare_q[f] <= wr_bit_a_f ? wd[`DCD_BIT_A_SPARE] : spare_q[f]; // R19
            csc_route_q[f] <= wr_bit_a_f ? wd[`DCD_BIT_A_CSC_ROUTE] : csc_route_q[f]; // R11
            pwr_down_q[f] <= pwr_d; // R1
            csc_irq_q[f] <= csc_d; // R16
         end
      end
   end

   // retry time-out counters: pci, card target a, card target b
   for (genvar k = 0; k < 3; k++) begin : g_retry
      dcd_event_timer #(.CNT_W(16)) u_retry (
         .i_ref_clk(i_ref_clk),
         .i_arst_n(i_arst_n),
         .i_run(i_retry_pending[k] & retry_en[k]),
         .i_limit(RETRY_LIM), // R18
         .o_expire(retry_exp[k])
      );
   end

   // delayed-transaction discard timers
   dcd_event_timer #(.CNT_W(16)) u_card_discard (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_run(i_card_discard_run),
      .i_limit(cb_sel_q ? DISC_SHORT : DISC_LONG), // R14
      .o_expire(o_card_side_discard_expire)
   );

   dcd_event_timer #(.CNT_W(16)) u_host_discard (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_run(i_host_discard_run),
      .i_limit(pci_sel_q ? DISC_SHORT : DISC_LONG), // R15
      .o_expire(o_host_side_discard_expire)
   );

   dcd_nand_tree #(.NAND_W(NAND_W)) u_nand (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_en(nand_en_q), // R7
      .i_pins(i_nand_pins),
      .o_out(o_nand_out)
   );

   // outputs
   assign o_cfg_ack = ack_q;
   assign o_cfg_rdata = rdata_q;
   assign o_sock_pwr_down = pwr_down_q;
   assign o_low_voltage_socket_force = lv_force_q;
   assign o_io_bit_a_bit = {io_bit_a_q[1], io_bit_a_q[0]};
   assign o_interrog_short = test_q; // R5
   assign o_irq_signaling_select = irq_mode_q;
   assign o_delayed_txn_disable = dt_dis_q;
   assign o_retry_latency_limit = lat_q;
   assign o_csc_irq = csc_irq_q;

   // checks
   pwr_lock_gate_a: assert property ( // R1
      i_pwr_down_req[0] && i_in_d3[0] && pwr_lock_q[0] |=> !o_sock_pwr_down[0])
      else $error("power-down passed while locked in d3");

   lv_force_write_a: assert property ( // R2
      wr_dev |=> o_low_voltage_socket_force == $past(i_cfg.wdata[6]))
      else $error("voltage force bit not updated by write");

   shared_func1_write_a: assert property ( // R17
      wr_dev && i_cfg.func |=> o_irq_signaling_select == $past(i_cfg.wdata[2:1]) ##1
      o_irq_signaling_select == $past(i_cfg.wdata[2:1], 2) || $past(wr_dev))
      else $error("function 1 write lost on shared mode field");

   reserved_reads_zero_a: assert property ( // R4
      i_cfg.valid && !i_cfg.wr && i_cfg.addr == `DCD_OFF_DEV_CTRL |=> o_cfg_ack && !o_cfg_rdata[4])
      else $error("reserved bit read back nonzero");

   id_mask_read_a: assert property ( // R10
      i_cfg.valid && !i_cfg.wr && hit_id && id_mask_q |=> o_cfg_rdata == 8'hff)
      else $error("masked id read not all ones");

   id_true_read_a: assert property ( // R10
      i_cfg.valid && !i_cfg.wr && i_cfg.addr == 8'h00 && !id_mask_q |=> o_cfg_rdata == VENDOR_ID[7:0])
      else $error("unmasked id read wrong");

   latency_limit_a: assert property ( // R13
      ##2 o_retry_latency_limit == ($past(rext_q, 2) ? 7'h40 : 7'h10) || $past(wr_bit_a, 2))
      else $error("retry latency limit mismatch");

   delayed_disable_a: assert property ( // R12
      wr_bit_a |=> o_delayed_txn_disable == $past(i_cfg.wdata[4]))
      else $error("delayed transaction disable not updated");

   retry_flag_set_a: assert property ( // R18
      retry_exp[0] |=> texp_q[0] [*2] or (texp_q[0] ##1 $past(wr_retry) && $past(i_cfg.wdata[1])))
      else $error("retry flag not held after expiry");

   set_beats_clear_a: assert property ( // R18
      retry_exp[1] && wr_retry && i_cfg.wdata[3] |=> texp_q[1])
      else $error("retry flag clear beat a new expiry");

   flag_clear_a: assert property ( // R18
      wr_retry && i_cfg.wdata[1] && !retry_exp[0] |=> !texp_q[0])
      else $error("write one did not clear retry flag");

   csc_route_a: assert property ( // R11
      i_card_status_change[1] && async_q && !csc_route_q[1] && i_compat_803_b4[1] |=> o_csc_irq[1])
      else $error("status change not routed by 803 bit");

   csc_sync_gate_a: assert property ( // R16
      !async_q && !i_clk_running |=> !o_csc_irq[0] && !o_csc_irq[1])
      else $error("status change interrupt raised without clock while not asynchronous");

   pwr_pass_free_a: assert property ( // R1
      i_pwr_down_req[1] && !(pwr_lock_q[1] && i_in_d3[1]) |=> o_sock_pwr_down[1])
      else $error("unlocked power-down request not passed");

   io_bit_a_write_a: assert property ( // R3
      wr_dev && !i_cfg.func |=> o_io_bit_a_bit[0] == $past(i_cfg.wdata[5]))
      else $error("function 0 diagnostic bit not updated by write");

   test_bit_write_a: assert property ( // R5
      wr_dev |=> o_interrog_short == $past(i_cfg.wdata[3]))
      else $error("test bit not updated by write");

   nand_enable_gate_a: assert property ( // R7
      !nand_en_q |=> !o_nand_out)
      else $error("nand tree output active while disabled");

   csc_nibble_route_a: assert property ( // R11
      i_card_status_change[0] && async_q && csc_route_q[0] && i_compat_805_hi[3:0] == 4'h0 |=> o_csc_irq[0])
      else $error("status change not routed by 805 nibble");

   csc_route_off_a: assert property ( // R11
      i_card_status_change[1] && !csc_route_q[1] && !i_compat_803_b4[1] |=> !o_csc_irq[1])
      else $error("status change routed with 803 bit clear");

   spare_storage_a: assert property ( // R19
      wr_bit_a && i_cfg.func |=> spare_q[1] == $past(i_cfg.wdata[6]))
      else $error("function 1 spare bit not updated by write");
endmodule

// ---- dcd_defines.svh ----
// offsets, bit positions, reset values and cycle counts of the device control and diagnostic bank
// assumes byte-wide configuration accesses with byte offsets
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH

`define DCD_OFF_RETRY_STAT 8'h90
`define DCD_OFF_DEV_CTRL 8'h92
`define DCD_OFF_BIT_A 8'h93
`define DCD_ID_WORD_IDX 6'h00

`define DCD_DEV_PWR_LOCK 7
`define DCD_DEV_LV_FORCE 6
`define DCD_DEV_IO_BIT_A 5
`define DCD_DEV_RSVD 4
`define DCD_DEV_TEST 3
`define DCD_DEV_IRQ_HI 2
`define DCD_DEV_IRQ_LO 1
`define DCD_DEV_NAND 0

`define DCD_BIT_A_ID_MASK 7
`define DCD_BIT_A_SPARE 6
`define DCD_BIT_A_CSC_ROUTE 5
`define DCD_BIT_A_DT_DIS 4
`define DCD_BIT_A_REXT 3
`define DCD_BIT_A_CB_SEL 2
`define DCD_BIT_A_PCI_SEL 1
`define DCD_BIT_A_ASYNC 0

`define DCD_RS_PCI_EN 7
`define DCD_RS_CB_EN 6
`define DCD_RS_TEXP_CBB 5
`define DCD_RS_TEXP_CBA 3
`define DCD_RS_TEXP_PCI 1

`define DCD_DEV_RST 8'h66
`define DCD_BIT_A_RST 8'h61
`define DCD_RETRY_RST 8'hc0

`define DCD_RETRY_CYC 32768
`define DCD_DISCARD_SHORT_CYC 1024
`define DCD_DISCARD_LONG_CYC 32768
`define DCD_RETRY_LAT_SHORT 7'h10
`define DCD_RETRY_LAT_LONG 7'h40

`endif

// ---- dcd_pkg.sv ----
// types shared by the device control and diagnostic bank
// assumes nothing beyond a SystemVerilog tool
package dcd_pkg;
   typedef enum logic [1:0] {
      DCD_IRQ_PARALLEL = 2'h0,
      DCD_IRQ_RESERVED = 2'h1,
      DCD_IRQ_SER_PAR = 2'h2,
      DCD_IRQ_SERIAL = 2'h3
   } dcd_irq_mode_t;

   typedef struct packed {
      logic valid;
      logic wr;
      logic func;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dcd_cfg_req_t;
endpackage

// ---- dcd_event_timer.sv ----
// run-length timer: pulses once when its run input has been high for i_limit cycles
// assumes run is a same-clock level that drops to restart the count
`timescale 1ns/1ps
module dcd_event_timer #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // control
   input wire logic i_run,
   input wire logic [CNT_W-1:0] i_limit,
   // event
   output logic o_expire
);
   logic [CNT_W-1:0] cnt_q;
   logic done_q;
   wire at_end = (cnt_q == (i_limit - CNT_W'(1)));

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= '0;
         done_q <= 1'h0;
         o_expire <= 1'h0;
      end else if (!i_run) begin
         cnt_q <= '0;
         done_q <= 1'h0;
         o_expire <= 1'h0;
      end else begin
         cnt_q <= done_q ? cnt_q : cnt_q + CNT_W'(1);
         done_q <= done_q | at_end;
         o_expire <= !done_q && at_end;
      end
   end
endmodule

// ---- dcd_nand_tree.sv ----
// nand tree diagnostic chain over the synchronised input and two-way pins
// assumes pins are asynchronous to the reference clock
`timescale 1ns/1ps
module dcd_nand_tree #(
   parameter int NAND_W = 8
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // control
   input wire logic i_en,
   // pins
   input wire logic [NAND_W-1:0] i_pins,
   // chain result
   output logic o_out
);
   logic [NAND_W-1:0] s1_q;
   logic [NAND_W-1:0] s2_q;
   logic [NAND_W-1:0] s3_q;
   logic [NAND_W-1:0] val_q;
   logic [NAND_W:0] chain;

   assign chain[0] = 1'h1;

   for (genvar i = 0; i < NAND_W; i++) begin : g_bit
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            s1_q[i] <= 1'h0;
            s2_q[i] <= 1'h0;
            s3_q[i] <= 1'h0;
            val_q[i] <= 1'h0;
         end else begin
            s1_q[i] <= i_pins[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            val_q[i] <= (s2_q[i] == s3_q[i]) ? s2_q[i] : val_q[i];
         end
      end
      assign chain[i+1] = ~(val_q[i] & chain[i]);
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_out <= 1'h0;
      end else begin
         o_out <= i_en & chain[NAND_W];
      end
   end
endmodule

// ---- dcd_host_model.sv ----
// host model: issues byte-wide configuration reads and writes to the bank
// assumes a one-cycle valid pulse and an acknowledge on the following edge
`timescale 1ns/1ps
module dcd_host_model (
   // clock
   input wire logic i_ref_clk,
   // configuration access
   output dcd_pkg::dcd_cfg_req_t o_cfg,
   input wire logic i_cfg_ack,
   input wire logic [7:0] i_cfg_rdata
);
   initial begin
      o_cfg = '0;
   end

   // one access; idle fields turned round so a stale value never looks held
   task automatic access(input logic wr, input logic fn, input logic [7:0] addr, input logic [7:0] wdata,
      output logic [7:0] rdata, output logic ok);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      o_cfg <= '{valid: 1'b1, wr: wr, func: fn, addr: addr, wdata: wdata};
      @(posedge i_ref_clk);
      o_cfg <= '{valid: 1'b0, wr: ~wr, func: ~fn, addr: ~addr, wdata: ~wdata};
      #1;
      while (i_cfg_ack !== 1'b1 && n < 4) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      ok = (i_cfg_ack === 1'b1);
      rdata = i_cfg_rdata;
   endtask
endmodule

// ---- dcd_regs_test.sv ----
// self-checking bench for the device control and diagnostic bank
// assumes the host model drives the configuration port; all other inputs come from here
`timescale 1ns/1ps
module dcd_regs_test;
   logic clk, arst_n, ack, lv, interrog, dtd, card_run, host_run, card_exp, host_exp, clk_run, nand_out;
   logic [1:0] pwr_req, in_d3, pwr_dn, io_bit_a, card_status_change, sc, c803;
   logic [7:0] rdata, c805, pins;
   logic [6:0] lat;
   logic [2:0] pend;
   dcd_pkg::dcd_cfg_req_t cfg;
   dcd_pkg::dcd_irq_mode_t irq_sel;
   int err_total = 0;
   int cmp_count = 0;
   localparam logic [15:0] VID = 16'hc3a5; // arbitrary value
   localparam logic [15:0] DID = 16'h5a3c; // arbitrary value

   dcd_host_model host (.i_ref_clk(clk), .o_cfg(cfg), .i_cfg_ack(ack), .i_cfg_rdata(rdata));
   dcd_regs #(.VENDOR_ID(VID), .DEVICE_ID(DID), .RETRY_CYC(32), .DISCARD_LONG_CYC(32),
      .DISCARD_SHORT_CYC(8), .NAND_W(8)) uut (
      .i_ref_clk(clk), .i_arst_n(arst_n), .i_cfg(cfg), .o_cfg_ack(ack), .o_cfg_rdata(rdata),
      .i_pwr_down_req(pwr_req), .i_in_d3(in_d3), .o_sock_pwr_down(pwr_dn),
      .o_low_voltage_socket_force(lv), .o_io_bit_a_bit(io_bit_a), .o_interrog_short(interrog),
      .o_irq_signaling_select(irq_sel), .o_delayed_txn_disable(dtd), .o_retry_latency_limit(lat),
      .i_retry_pending(pend), .i_card_discard_run(card_run), .i_host_discard_run(host_run),
      .o_card_side_discard_expire(card_exp), .o_host_side_discard_expire(host_exp),
      .i_card_status_change(sc), .i_compat_803_b4(c803), .i_compat_805_hi(c805),
      .i_clk_running(clk_run), .o_csc_irq(card_status_change), .i_nand_pins(pins), .o_nand_out(nand_out));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic fn, input logic [7:0] addr, input logic [7:0] d);
      logic [7:0] r;
      logic ok;
      host.access(1'b1, fn, addr, d, r, ok);
      check("write ack", {7'h0, ok}, 8'h01);
   endtask

   task automatic rd(input logic fn, input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] r;
      logic ok;
      host.access(1'b0, fn, addr, 8'h00, r, ok);
      check("read ack", {7'h0, ok}, 8'h01);
      check($sformatf("reg %h", addr), r, exp);
   endtask

   task automatic t_reset_values();
      rd(0, 8'h92, 8'h66);
      rd(0, 8'h93, 8'h61);
      rd(0, 8'h90, 8'hc0);
      check("lv force", {7'h0, lv}, 8'h01);
      check("io bit_a", {6'h0, io_bit_a}, 8'h03);
      check("irq select", {6'h0, irq_sel}, 8'h03);
      check("latency", {1'b0, lat}, 8'h10);
      check("nand off", {7'h0, nand_out}, 8'h00);
   endtask

   task automatic t_dev_ctrl();
      for (int m = 0; m < 4; m++) begin
         wr(0, 8'h92, 8'h70 | 8'(m << 1));
         rd(0, 8'h92, 8'h60 | 8'(m << 1));
         check("irq select", {6'h0, irq_sel}, 8'(m));
      end
      wr(0, 8'h92, 8'h00);
      tick(1);
      check("lv force", {7'h0, lv}, 8'h00);
      check("io bit_a", {6'h0, io_bit_a}, 8'h02);
      check("test bit", {7'h0, interrog}, 8'h00);
      rd(1, 8'h92, 8'h20);
      wr(0, 8'h92, 8'h66);
      rd(1, 8'h92, 8'h66);
   endtask

   task automatic t_power_lock();
      @(posedge clk);
      pwr_req <= 2'b11;
      in_d3 <= 2'b11;
      tick(3);
      check("pwr down", {6'h0, pwr_dn}, 8'h03);
      wr(0, 8'h92, 8'he6);
      tick(2);
      check("pwr down locked", {6'h0, pwr_dn}, 8'h02);
      @(posedge clk) in_d3 <= 2'b10;
      tick(3);
      check("pwr down awake", {6'h0, pwr_dn}, 8'h03);
      @(posedge clk) pwr_req <= 2'b00;
      wr(0, 8'h92, 8'h66);
   endtask

   task automatic t_id_mask();
      for (int i = 0; i < 4; i++) rd(0, 8'(i), 8'({DID, VID} >> (8 * i)));
      wr(0, 8'h93, 8'he1);
      for (int i = 0; i < 4; i++) rd(0, 8'(i), 8'hff);
      wr(0, 8'h93, 8'h79);
      tick(2);
      check("dt disable", {7'h0, dtd}, 8'h01);
      check("latency", {1'b0, lat}, 8'h40);
      wr(0, 8'h93, 8'h61);
      tick(2);
      check("dt disable", {7'h0, dtd}, 8'h00);
      check("latency", {1'b0, lat}, 8'h10);
   endtask

   task automatic t_discard();
      int kc;
      int kh;
      for (int p = 0; p < 2; p++) begin
         kc = 0;
         kh = 0;
         wr(0, 8'h93, p ? 8'h63 : 8'h65);
         @(posedge clk);
         card_run <= 1'b1;
         host_run <= 1'b1;
         for (int k = 1; k <= 40; k++) begin
            tick(1);
            if (card_exp === 1'b1 && kc == 0) kc = k;
            if (host_exp === 1'b1 && kh == 0) kh = k;
         end
         check("card period", 8'(kc), p ? 8'h20 : 8'h08);
         check("host period", 8'(kh), p ? 8'h08 : 8'h20);
         @(posedge clk);
         card_run <= 1'b0;
         host_run <= 1'b0;
      end
      wr(0, 8'h93, 8'h61);
   endtask

   task automatic t_csc();
      @(posedge clk);
      sc <= 2'b11;
      c803 <= 2'b11;
      c805 <= 8'h10;
      tick(3);
      check("csc nibble", {6'h0, card_status_change}, 8'h01);
      wr(1, 8'h93, 8'h41);
      tick(2);
      check("csc bit4", {6'h0, card_status_change}, 8'h03);
      @(posedge clk) c803 <= 2'b01;
      tick(3);
      check("csc bit4 off", {6'h0, card_status_change}, 8'h01);
      wr(0, 8'h93, 8'h60);
      tick(2);
      check("csc sync idle", {6'h0, card_status_change}, 8'h00);
      @(posedge clk) clk_run <= 1'b1;
      tick(3);
      check("csc sync run", {6'h0, card_status_change}, 8'h01);
      @(posedge clk) sc <= 2'b00;
      wr(0, 8'h93, 8'h61);
   endtask

   task automatic t_retry();
      @(posedge clk) pend <= 3'b001;
      tick(20);
      rd(0, 8'h90, 8'hc0);
      tick(20);
      rd(0, 8'h90, 8'hc2);
      @(posedge clk) pend <= 3'b000;
      wr(0, 8'h90, 8'hc2);
      rd(0, 8'h90, 8'hc0);
      wr(0, 8'h90, 8'h40);
      @(posedge clk) pend <= 3'b111;
      tick(45);
      rd(0, 8'h90, 8'h68);
      @(posedge clk) pend <= 3'b000;
      wr(0, 8'h90, 8'he8);
      rd(0, 8'h90, 8'hc0);
      // clear lands on the edge of a fresh expiry of card target a
      @(posedge clk) pend <= 3'b010;
      tick(31);
      wr(0, 8'h90, 8'hc8);
      rd(0, 8'h90, 8'hc8);
      @(posedge clk) pend <= 3'b000;
   endtask

   task automatic t_nand();
      wr(0, 8'h92, 8'h67);
      tick(6);
      check("nand high", {7'h0, nand_out}, 8'h01);
      @(posedge clk) pins <= 8'hfe;
      tick(6);
      check("nand low", {7'h0, nand_out}, 8'h00);
      @(posedge clk) pins <= 8'hff;
      wr(0, 8'h92, 8'h66);
   endtask

   task automatic t_second_reset();
      wr(0, 8'h92, 8'h00);
      @(posedge clk);
      arst_n <= 1'b0;
      tick(2);
      @(posedge clk) arst_n <= 1'b1;
      rd(0, 8'h92, 8'h66);
      rd(0, 8'h90, 8'hc0);
   endtask

   task automatic print_verdict();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_total++;
      print_verdict();
   end

   initial begin
      arst_n = 1'b0;
      {pwr_req, in_d3, pend, card_run, host_run, sc, c803, clk_run} = '0;
      c805 = 8'h00;
      pins = 8'hff;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      t_reset_values();
      t_dev_ctrl();
      t_nand();
      t_power_lock();
      t_id_mask();
      t_discard();
      t_csc();
      t_retry();
      t_second_reset();
      print_verdict();
   end
endmodule
